// ==== dv/tcrj_cmd_checker_tb_top.sv ====
`timescale 1ns/1ps
`include "tcrj_consts.svh"
module tcrj_cmd_checker_tb_top import tcrj_pkg::*;;
  logic clk, rstn, opt_ac, opt_amps, reg_wr, reg_rd, ch_vld, ren_pin, jdat_vld;
  logic x_d = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] ch_data;
  logic [15:0] jdat, cref_q, v;
  logic [3:0] reg_addr, range_q, e_err, e_range;
  logic [31:0] reg_wdata, reg_rdata;
  logic [2:0] func_q, tc_sel_q, e_func;
  logic temp_mode_q, scale_c_q, filt_on_q, meas_req_q, cref_load_q, srq_q, e_filt;
  tcrj_err_s err_q;
  tcrj_msg_e disp_msg_q;
  int failures = 0;
  int checks = 0;
  integer seed = 32'h3f9c92bd;
  logic [16:0] sq[$];
  logic [31:0] rq[$];
  logic [15:0] cq[$];

  // Clock of 5 ns
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Message time shortened so the run stays short
  tcrj_cmd_checker #(.DISP_CYC(16)) dut_u (
    .clk(clk), .rstn(rstn), .ch_vld(ch_vld), .ch_data(ch_data), .ren_pin(ren_pin),
    .opt_ac_fitted(opt_ac), .opt_amps_fitted(opt_amps), .jdat_vld(jdat_vld), .jdat(jdat),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .func_q(func_q), .range_q(range_q), .temp_mode_q(temp_mode_q),
    .scale_c_q(scale_c_q), .tc_sel_q(tc_sel_q), .filt_on_q(filt_on_q), .meas_req_q(meas_req_q),
    .cref_q(cref_q), .cref_load_q(cref_load_q), .err_q(err_q), .srq_q(srq_q), .disp_msg_q(disp_msg_q)
  );

  tcrj_host_model host_u (
    .clk(clk), .ch_vld(ch_vld), .ch_data(ch_data), .ren_pin(ren_pin),
    .meas_req_q(meas_req_q), .jdat_vld(jdat_vld), .jdat(jdat)
  );

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Expected state word, thermocouple type worked out from range
  function automatic logic [16:0] ev();
    logic tm;
    tm = (e_func == `TC_F_FAHR) || (e_func == `TC_F_CELS);
    return {e_err, e_func, e_range,
      (tm && e_range >= `TC_R_TC_LO && e_range <= `TC_R_TC_HI) ? 3'(e_range - 4'h1) : 3'h0,
      e_filt, e_func == `TC_F_CELS, tm};
  endfunction

  task automatic cmd(input string s);
    sq.push_back(ev());
    host_u.send(s);
    repeat (2) @(posedge clk);
  endtask

  // Rejected string: sticky cause bits, message shown then withdrawn
  task automatic bad(input string s, input logic [3:0] bits, input logic [1:0] msg);
    e_err = e_err | bits;
    cmd(s);
    #1;
    chk("message", 32'(disp_msg_q), 32'(msg));
    repeat (18) @(posedge clk);
    #1;
    chk("message_end", 32'(disp_msg_q), 32'h0);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask

  // Monitor: each result taken against the oldest note, on the falling edge where outputs have settled
  always @(negedge clk) begin
    x_d <= ch_vld && ch_data == `TC_CH_X;
    rd_d <= reg_rd;
    if (x_d) chk("state", 32'({err_q, func_q, range_q, tc_sel_q, filt_on_q, scale_c_q, temp_mode_q}),
      32'(sq.pop_front()));
    if (rd_d) chk("reg", reg_rdata, rq.pop_front());
    if (cref_load_q) chk("cref", 32'(cref_q), 32'(cq.pop_front()));
  end

  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_sim();
  end

  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    opt_ac = 1'b0;
    opt_amps = 1'b0;
    e_err = 4'h0;
    e_func = `TC_RST_FUNC;
    e_range = `TC_RST_RANGE;
    e_filt = `TC_RST_FILT;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(`TC_ADDR_CFG, 32'h0000_0400);
    rd(4'hF, 32'h0);
    wr(`TC_ADDR_CTRL, 32'h1);
    rd(`TC_ADDR_CTRL, 32'h1);
    bad("F5X", 4'b0011, 2'h1);
    chk("srq", 32'(srq_q), 32'h1);
    @(posedge clk);
    host_u.ren_pin <= 1'b1;
    repeat (6) @(posedge clk);
    wr(`TC_ADDR_ERR, 32'hF);
    e_err = 4'h0;
    rd(`TC_ADDR_ERR, 32'h0);
    e_func = 3'h6;
    e_range = 4'h2;
    cmd("F6R2N1X");
    // Every thermocouple range, filter toggled each time
    for (int r = 2; r <= 8; r++) begin
      e_func = 3'h5;
      e_range = r[3:0];
      e_filt = r[0];
      cmd($sformatf("F5R%0dN%0dX", r, r % 2));
    end
    bad("F6E1X", 4'b0101, 2'h2);
    bad("R2N9X", 4'b1001, 2'h3);
    bad("O0E1X", 4'b0000, 2'h2);
    bad("F1X", 4'b0000, 2'h3);
    bad("F4X", 4'b0000, 2'h3);
    @(posedge clk);
    opt_amps <= 1'b1;
    bad("F3X", 4'b0000, 2'h3);
    @(posedge clk);
    opt_ac <= 1'b1;
    // Fitted options make functions 1, 3 and 4 legal; function 2 is legal without them
    for (int f = 1; f <= 4; f++) begin
      e_func = 3'(f);
      cmd($sformatf("F%0dX", f));
    end
    e_func = 3'h6;
    e_range = 4'h3;
    cmd("F6R3X");
    v = 16'($unsigned($random(seed)) % 2000);
    cq.push_back(v);
    cmd($sformatf("V%0d.%0dO1X", v / 10, v % 10));
    rd(`TC_ADDR_REF, {v, v});
    // Negative supplied value, sign taken after the value letter
    cq.push_back(16'hFFF4);
    cmd("V-12O1X");
    // Repeated measured acquisition, prompt then slow scanner
    for (int k = 0; k < 2; k++) begin
      host_u.jdel = 1 + 8 * k;
      host_u.jval = 16'($random(seed));
      cq.push_back(host_u.jval);
      cmd("O0X");
      repeat (14) @(posedge clk);
    end
    repeat (20) @(posedge clk);
    chk("queues", 32'(sq.size() + rq.size() + cq.size()), 32'h0);
    end_sim();
  end
endmodule // tcrj_cmd_checker_tb_top

// ==== dv/tcrj_host_model.sv ====
`timescale 1ns/1ps
module tcrj_host_model (
  input wire logic clk,
  output logic ch_vld,
  output logic [7:0] ch_data,
  output logic ren_pin,
  input wire logic meas_req_q,
  output logic jdat_vld,
  output logic [15:0] jdat
);
  int jdel = 1;
  logic [15:0] jval = 16'h0000;
  // Idle levels at time zero
  initial begin
    ch_vld = 1'b0;
    ch_data = 8'h00;
    ren_pin = 1'b0;
    jdat_vld = 1'b0;
    jdat = 16'hFFFF;
  end
  // Whole string back to back; value digits are already in scale units
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk);
      ch_vld <= 1'b1;
      ch_data <= s[i];
    end
    @(posedge clk);
    ch_vld <= 1'b0;
    ch_data <= ~s[s.len()-1]; // Idle bus never shows a stale char
  endtask
  // Scanner answers a junction request after jdel cycles, prompt or slow
  always @(posedge clk) begin
    if (meas_req_q) begin
      repeat (jdel) @(posedge clk);
      jdat_vld <= 1'b1;
      jdat <= jval;
      @(posedge clk);
      jdat_vld <= 1'b0;
      jdat <= ~jval; // Sample no longer held
    end
  end
endmodule // tcrj_host_model

// ==== rtl/tcrj_cmd_checker.sv ====
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "tcrj_consts.svh"
module tcrj_cmd_checker import tcrj_pkg::*; #(
  parameter int unsigned DISP_CYC = `TC_DISP_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ch_vld,
  input wire logic [7:0] ch_data,
  input wire logic ren_pin,
  input wire logic opt_ac_fitted,
  input wire logic opt_amps_fitted,
  input wire logic jdat_vld,
  input wire logic [15:0] jdat,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [2:0] func_q,
  output logic [3:0] range_q,
  output logic temp_mode_q,
  output logic scale_c_q,
  output logic [2:0] tc_sel_q,
  output logic filt_on_q,
  output logic meas_req_q,
  output logic [15:0] cref_q,
  output logic cref_load_q,
  output tcrj_err_s err_q,
  output logic srq_q,
  output tcrj_msg_e disp_msg_q
);

  function automatic logic [7:0] upcase(input logic [7:0] c);
    upcase = (c >= 8'h61 && c <= 8'h7A) ? (c - 8'h20) : c;
  endfunction

  function automatic logic in_rng(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi);
    in_rng = (c >= lo) && (c <= hi);
  endfunction

  // Remote enable comes from a pin: three stages, accepted when the last two agree
  logic ren_m1_q, ren_m2_q, ren_m3_q, ren_s_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ren_m1_q <= 1'h0;
      ren_m2_q <= 1'h0;
      ren_m3_q <= 1'h0;
      ren_s_q <= 1'h0;
    end else begin
      ren_m1_q <= ren_pin;
      ren_m2_q <= ren_m1_q;
      ren_m3_q <= ren_m2_q;
      ren_s_q <= (ren_m2_q == ren_m3_q) ? ren_m3_q : ren_s_q;
    end
  end

  // Parser state: current letter, its option digits and the pending string
  tcrj_cmd_e cur_q, cur_d;
  logic [15:0] opt_q, opt_d;
  logic dig_q, dig_d, neg_q, neg_d;
  tcrj_pend_s pend_q, pend_d, pn;
  logic [7:0] c;
  logic ex, norem, ok;

  // Each command is closed when the next letter or the execute character arrives
  always_comb begin
    cur_d = cur_q;
    opt_d = opt_q;
    dig_d = dig_q;
    neg_d = neg_q;
    pn = pend_q;
    ex = 1'b0;
    c = upcase(ch_data);
    if (ch_vld) begin
      if (in_rng(c, `TC_CH_ZERO, `TC_CH_NINE)) begin
        opt_d = 16'(opt_q * 16'h000A + {8'h00, c - `TC_CH_ZERO});
        dig_d = 1'b1;
      end else if (c == `TC_CH_MINUS && cur_q == TCRJ_C_V) begin
        neg_d = 1'b1;
      end else if (in_rng(c, `TC_CH_A, `TC_CH_Z)) begin
        unique case (cur_q)
          TCRJ_C_NONE: ;
          TCRJ_C_F: begin
            if (!dig_q || opt_q > `TC_F_MAX) pn.io = 1'b1;
            else if ((opt_q == `TC_F_ACV && !opt_ac_fitted) ||
                     (opt_q == `TC_F_ACA && !(opt_ac_fitted && opt_amps_fitted)) ||
                     (opt_q == `TC_F_DCA && !opt_amps_fitted)) pn.io = 1'b1;
            else begin
              pn.f_v = 1'b1;
              pn.f = opt_q[2:0];
            end
          end
          TCRJ_C_R: begin
            if (!dig_q || opt_q > `TC_R_MAX) pn.io = 1'b1;
            else begin
              pn.r_v = 1'b1;
              pn.r = opt_q[3:0];
            end
          end
          TCRJ_C_O: begin
            if (!dig_q || opt_q > `TC_OPT_MAX) pn.io = 1'b1;
            else begin
              pn.o_v = 1'b1;
              pn.o = opt_q[0];
            end
          end
          TCRJ_C_N: begin
            if (!dig_q || opt_q > `TC_OPT_MAX) pn.io = 1'b1;
            else begin
              pn.n_v = 1'b1;
              pn.n = opt_q[0];
            end
          end
          TCRJ_C_V: begin
            pn.v_v = 1'b1;
            pn.v = neg_q ? 16'(-opt_q) : opt_q;
          end
          default: pn.ic = 1'b1;
        endcase
        opt_d = 16'h0000;
        dig_d = 1'b0;
        neg_d = 1'b0;
        if (c == `TC_CH_X) begin
          ex = 1'b1;
          cur_d = TCRJ_C_NONE;
        end else if (c == `TC_CH_F) cur_d = TCRJ_C_F;
        else if (c == `TC_CH_R) cur_d = TCRJ_C_R;
        else if (c == `TC_CH_O) cur_d = TCRJ_C_O;
        else if (c == `TC_CH_N) cur_d = TCRJ_C_N;
        else if (c == `TC_CH_V) cur_d = TCRJ_C_V;
        else cur_d = TCRJ_C_BAD;
      end
    end
    pend_d = ex ? '0 : pn;
  end

  // Remote enable is looked at only when the string executes
  assign norem = !ren_s_q;
  assign ok = !norem && !pn.ic && !pn.io;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cur_q <= TCRJ_C_NONE;
      opt_q <= 16'h0000;
      dig_q <= 1'h0;
      neg_q <= 1'h0;
      pend_q <= '0;
    end else begin
      cur_q <= cur_d;
      opt_q <= opt_d;
      dig_q <= dig_d;
      neg_q <= neg_d;
      pend_q <= pend_d;
    end
  end

  // Configuration, junction handling, error word, display and register port
  logic [2:0] func_d, tc_sel_d;
  logic [3:0] range_d;
  logic temp_mode_d, scale_c_d, filt_on_d, meas_req_d, cref_load_d, srq_d;
  logic meas_wait_q, meas_wait_d, ctrl_srq_q, ctrl_srq_d, jmode_q, jmode_d;
  logic [15:0] val_q, val_d, vnew, cref_d;
  tcrj_err_s err_d;
  tcrj_msg_e disp_msg_d;
  logic [31:0] dtmr_q, dtmr_d, rdata_d;

  always_comb begin
    func_d = func_q;
    range_d = range_q;
    filt_on_d = filt_on_q;
    val_d = val_q;
    cref_d = cref_q;
    jmode_d = jmode_q;
    meas_wait_d = meas_wait_q;
    meas_req_d = 1'b0;
    cref_load_d = 1'b0;
    err_d = err_q;
    disp_msg_d = disp_msg_q;
    dtmr_d = dtmr_q;
    ctrl_srq_d = ctrl_srq_q;
    vnew = pn.v_v ? pn.v : val_q;
    // Junction reading is taken only while a measurement is awaited
    if (meas_wait_q && jdat_vld) begin
      cref_d = jdat;
      cref_load_d = 1'b1;
      meas_wait_d = 1'b0;
    end
    // Message holds for its time, then normal display returns
    if (dtmr_q != 32'h0000_0000) begin
      dtmr_d = dtmr_q - 32'h0000_0001;
      if (dtmr_q == 32'h0000_0001) disp_msg_d = TCRJ_M_NONE;
    end
    // Software clears error bits by writing ones; a new error in the same cycle wins
    if (reg_wr && reg_addr == `TC_ADDR_ERR) err_d = err_q & ~tcrj_err_s'(reg_wdata[3:0]);
    if (reg_wr && reg_addr == `TC_ADDR_CTRL) ctrl_srq_d = reg_wdata[0];
    if (ex && !ok) begin
      err_d.gen = 1'b1;
      // Built on the cleared word so a clear of an unrelated bit is not undone
      err_d.norem = err_d.norem | norem;
      err_d.illegal_command_error = err_d.illegal_command_error | pn.ic;
      err_d.illegal_option_error = err_d.illegal_option_error | pn.io;
      // Only one message fits; a missing remote hides the syntax faults
      disp_msg_d = norem ? TCRJ_M_NOREM :
                   (pn.ic ? TCRJ_M_ILLEGAL_COMMAND_ERROR : TCRJ_M_ILLEGAL_OPTION_ERROR);
      dtmr_d = DISP_CYC;
    end else if (ex) begin
      // Whole string is applied at once; a faulty one touches none of it
      if (pn.f_v) func_d = pn.f;
      if (pn.r_v) range_d = pn.r;
      if (pn.n_v) filt_on_d = pn.n;
      val_d = vnew;
      if (pn.o_v && !pn.o) begin
        meas_req_d = 1'b1;
        meas_wait_d = 1'b1;
        jmode_d = 1'b0;
      end else if (pn.o_v) begin
        cref_d = vnew;
        cref_load_d = 1'b1;
        meas_wait_d = 1'b0;
        jmode_d = 1'b1;
      end
    end
    temp_mode_d = (func_d == `TC_F_FAHR) || (func_d == `TC_F_CELS);
    scale_c_d = (func_d == `TC_F_CELS);
    tc_sel_d = (temp_mode_d && range_d >= `TC_R_TC_LO && range_d <= `TC_R_TC_HI) ?
               3'(range_d - 4'h1) : 3'h0;
    srq_d = ctrl_srq_q && err_d.gen;
    // Read data stand in the cycle after the strobe only
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `TC_ADDR_ERR: rdata_d = {28'h000_0000, err_q};
        `TC_ADDR_CFG: rdata_d = {17'h0_0000, meas_wait_q, jmode_q, scale_c_q, temp_mode_q, filt_on_q,
                                 tc_sel_q, range_q, func_q};
        `TC_ADDR_REF: rdata_d = {val_q, cref_q};
        `TC_ADDR_CTRL: rdata_d = {31'h0000_0000, ctrl_srq_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      func_q <= `TC_RST_FUNC;
      range_q <= `TC_RST_RANGE;
      filt_on_q <= `TC_RST_FILT;
      temp_mode_q <= 1'h0;
      scale_c_q <= 1'h0;
      tc_sel_q <= 3'h0;
      val_q <= 16'h0000;
      cref_q <= 16'h0000;
      jmode_q <= 1'h0;
      meas_wait_q <= 1'h0;
      meas_req_q <= 1'h0;
      cref_load_q <= 1'h0;
      err_q <= '0;
      srq_q <= 1'h0;
      ctrl_srq_q <= 1'h0;
      disp_msg_q <= TCRJ_M_NONE;
      dtmr_q <= 32'h0000_0000;
      reg_rdata <= 32'h0000_0000;
    end else begin
      func_q <= func_d;
      range_q <= range_d;
      filt_on_q <= filt_on_d;
      temp_mode_q <= temp_mode_d;
      scale_c_q <= scale_c_d;
      tc_sel_q <= tc_sel_d;
      val_q <= val_d;
      cref_q <= cref_d;
      jmode_q <= jmode_d;
      meas_wait_q <= meas_wait_d;
      meas_req_q <= meas_req_d;
      cref_load_q <= cref_load_d;
      err_q <= err_d;
      srq_q <= srq_d;
      ctrl_srq_q <= ctrl_srq_d;
      disp_msg_q <= disp_msg_d;
      dtmr_q <= dtmr_d;
      reg_rdata <= rdata_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_MEASURE: assert property (ex && ok && pn.o_v && !pn.o |=> meas_req_q && meas_wait_q)
    else $error("measure command did not request a junction reading");
  AST_SUPPLIED: assert property (ex && ok && pn.o_v && pn.o |=> cref_load_q && cref_q == $past(vnew))
    else $error("supplied junction value not loaded");
  AST_SCALE: assert property (ex && ok && pn.f_v && pn.f == `TC_F_FAHR |=> temp_mode_q && !scale_c_q)
    else $error("fahrenheit temperature mode not entered");
  AST_TC_TYPE: assert property (ex && ok && pn.f_v && pn.f == `TC_F_CELS && pn.r_v && pn.r == 4'h2
                                |=> scale_c_q && tc_sel_q == 3'h1)
    else $error("range 2 did not select the first thermocouple type");
  AST_JUNC_SAFE: assert property (!meas_wait_q && !(ex && ok && pn.o_v) |=> $stable(cref_q))
    else $error("junction value changed without a junction command");
  AST_FILTER: assert property (ex && ok && pn.n_v |=> filt_on_q == $past(pn.n))
    else $error("filter did not follow its option");
  AST_DISCARD: assert property (ex && !ok |=> $stable(func_q) && $stable(range_q) && $stable(filt_on_q)
                                && !meas_req_q && (!cref_load_q || $past(meas_wait_q)))
    else $error("faulty string was partly executed");
  AST_NOREMOTE: assert property (ex && !ren_s_q |=> err_q.gen && err_q.norem && disp_msg_q == TCRJ_M_NOREM)
    else $error("no-remote error not flagged");
  AST_ILLCMD: assert property (ex && ren_s_q && pn.ic |=> err_q.illegal_command_error && err_q.gen)
    else $error("illegal command not flagged");
  AST_ILLOPT: assert property (ex && pn.io |=> err_q.illegal_option_error && err_q.gen)
    else $error("illegal option not flagged");
  AST_MSG_HOLD: assert property (ex && !ok |=> (disp_msg_q != TCRJ_M_NONE) [*8])
    else $error("error message dropped too early");
  AST_BUFFERED: assert property (!ex |=> $stable(func_q) && $stable(range_q) && $stable(filt_on_q))
    else $error("command applied before the execute character");

  COV_MEASURE: cover property (ex && ok && pn.o_v && !pn.o ##[1:20] cref_load_q);
  COV_SUPPLIED: cover property (ex && ok && pn.v_v && pn.o_v && pn.o);
  COV_NOREM: cover property (ex && norem);
  COV_ILLOPT: cover property (ex && ok == 1'b0 && pn.io && !pn.ic);

endmodule // tcrj_cmd_checker

// ==== rtl/tcrj_consts.svh ====
// Functional notes
// - Measure-junction command measures junction itself, applies it for selected thermocouple type.
// - Supplied-junction command loads earlier value as junction temperature and compensates.
// - One function code enters Fahrenheit temperature mode, the other Celsius.
// - In temperature mode range codes 2 to 8 select types K,J,T,E,R,S,B.
// - Displayed junction reading during measurement never corrupts linearization.
// - Filter option 0 disables exponential filter, option 1 enables it.
// - No-remote, illegal command or illegal option discards the whole string.
// - Remote enable sampled only at execute character; false gives no-remote error.
// - Undefined command letter raises illegal-command error.
// - Valid letter with unsupported option raises illegal-option error.
// - AC volts, AC amps or DC amps without fitted option is illegal option.
// - Bus error sets general and cause bits of error word; service request optional.
// - Error message shown about one second, then normal display returns.
`ifndef TCRJ_CONSTS_SVH
`define TCRJ_CONSTS_SVH
// Register offsets on the plain register port
`define TC_ADDR_ERR 4'h0
`define TC_ADDR_CFG 4'h1
`define TC_ADDR_REF 4'h2
`define TC_ADDR_CTRL 4'h3
// Command characters, upper case
`define TC_CH_X 8'h58
`define TC_CH_F 8'h46
`define TC_CH_R 8'h52
`define TC_CH_O 8'h4F
`define TC_CH_N 8'h4E
`define TC_CH_V 8'h56
`define TC_CH_MINUS 8'h2D
`define TC_CH_ZERO 8'h30
`define TC_CH_NINE 8'h39
`define TC_CH_A 8'h41
`define TC_CH_Z 8'h5A
// Function, range and option codes
`define TC_F_ACV 16'h0001
`define TC_F_ACA 16'h0003
`define TC_F_DCA 16'h0004
`define TC_F_FAHR 3'h5
`define TC_F_CELS 3'h6
`define TC_F_MAX 16'h0006
`define TC_R_MAX 16'h0008
`define TC_R_TC_LO 4'h2
`define TC_R_TC_HI 4'h8
`define TC_OPT_MAX 16'h0001
// Reset values
`define TC_RST_FUNC 3'h0
`define TC_RST_RANGE 4'h0
`define TC_RST_FILT 1'h1
// Message hold time
`define TC_DISP_MS 1000
`define TC_CLK_MHZ 200
`define TC_DISP_CYC (`TC_DISP_MS * `TC_CLK_MHZ * 1000)
`endif

// ==== rtl/tcrj_pkg.sv ====
package tcrj_pkg;
  typedef enum logic [2:0] {
    TCRJ_C_NONE = 3'b000,
    TCRJ_C_F = 3'b001,
    TCRJ_C_R = 3'b010,
    TCRJ_C_O = 3'b011,
    TCRJ_C_N = 3'b100,
    TCRJ_C_V = 3'b101,
    TCRJ_C_BAD = 3'b110
  } tcrj_cmd_e;
  typedef enum logic [1:0] {
    TCRJ_M_NONE = 2'b00,
    TCRJ_M_NOREM = 2'b01,
    TCRJ_M_ILLEGAL_COMMAND_ERROR = 2'b10,
    TCRJ_M_ILLEGAL_OPTION_ERROR = 2'b11
  } tcrj_msg_e;
  typedef struct packed {
    logic illegal_option_error;
    logic illegal_command_error;
    logic norem;
    logic gen;
  } tcrj_err_s;
  // Commands gathered from one string, waiting for the execute character
  typedef struct packed {
    logic f_v;
    logic [2:0] f;
    logic r_v;
    logic [3:0] r;
    logic o_v;
    logic o;
    logic n_v;
    logic n;
    logic v_v;
    logic [15:0] v;
    logic ic;
    logic io;
  } tcrj_pend_s;
endpackage
